// ==== dttl_core.v ====
// transfer, swap and table lookup datapath of a 4-bit core
// assumes data and program memories answer within the cycle in which
// the read strobe stands; instructions arrive decoded from the sequencer

`include "dttl_defines.vh"

// Behaviour
// [RULE_01] post-increment adds one to low pointer nibble; wrap to 0 skips next
// [RULE_02] post-decrement subtracts one from low pointer; reaching F skips next
// [RULE_03] single moves and swaps pick main, inc, dec, second or mixed pointer
// [RULE_04] pair load puts addressed nibble in A, next nibble in X
// [RULE_05] pair access via main pointer clears address bit 0 when odd
// [RULE_06] pair store writes A then X at the even-aligned pair address
// [RULE_07] single direct moves accept any 8-bit address up to the top
// [RULE_08] software gives only even direct addresses for pair moves and swaps
// [RULE_09] any single register copies into A, and A into any other
// [RULE_10] any pair incl. alternate bank copies into acc pair, and back
// [RULE_11] swap exchanges A with the memory nibble, each getting the other
// [RULE_12] pointer swaps with inc or dec update low nibble and may skip
// [RULE_13] pair swap exchanges A and X with the aligned memory pair
// [RULE_14] A swaps with any register, the acc pair with any pair
// [RULE_15] second-pair page lookup keeps upper counter bits, low byte from pair
// [RULE_16] table byte low nibble goes to A, high nibble to X
// [RULE_17] table reads never alter the program counter
// [RULE_18] page lookup at page end byte uses the following page
// [RULE_19] accumulator-pair page lookup: upper counter bits, acc pair low
// [RULE_20] absolute lookup address is B, C, D, E with B most significant
// [RULE_21] software clears B on the smaller variant before absolute lookups
// [RULE_22] a skipped instruction is taken but changes nothing
module dttl_core (
    input wire clock,
    input wire rst_b,
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [2:0] ptr_sel,
    input wire [2:0] reg_sel,
    input wire [2:0] pair_sel,
    input wire [7:0] dir_addr,
    input wire [11:0] pc_in,
    input wire [3:0] dm_rdata,
    input wire [7:0] pm_rdata,
    output reg [7:0] dm_addr_ff,
    output reg [3:0] dm_wdata_ff,
    output reg dm_we_ff,
    output reg dm_re_ff,
    output reg [15:0] pm_addr_ff,
    output reg pm_re_ff,
    output reg busy_ff,
    output reg done_ff,
    output reg skipped_ff,
    output reg skip_ff,
    output wire [7:0] acc_pair_out,
    output wire [7:0] main_pointer_pair_out,
    output wire [7:0] second_pair_out,
    output wire [7:0] third_pair_out
);

    localparam ST_IDLE = 3'h0;
    localparam ST_RD1 = 3'h1;
    localparam ST_RD2 = 3'h2;
    localparam ST_WR2 = 3'h3;
    localparam ST_TBL = 3'h4;

    reg [2:0] state_ff;
    reg [4:0] op_ff;
    reg [2:0] ptr_ff;
    reg [7:0] base_ff;
    reg [3:0] tmp_ff;
    wire [63:0] rf_flat;

    reg [2:0] nxt_state;
    reg [4:0] nxt_op;
    reg [2:0] nxt_ptr;
    reg [7:0] nxt_base;
    reg [3:0] nxt_tmp;
    reg [63:0] nxt_rf;
    reg [7:0] nxt_dm_addr;
    reg [3:0] nxt_dm_wdata;
    reg nxt_dm_we;
    reg nxt_dm_re;
    reg [15:0] nxt_pm_addr;
    reg nxt_pm_re;
    reg nxt_done;
    reg nxt_skipped;
    reg nxt_skip;
    reg finish;
    reg [2:0] fin_ptr;
    reg [3:0] new_l;

    // register file nibbles, bank 0 in slots 0-7, alternate bank in 8-15
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_rf
            reg [3:0] nib_ff;
            always @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                    nib_ff <= `DTTL_RST_NIB;
                else
                    nib_ff <= nxt_rf[gi*4 +: 4];
            end
            assign rf_flat[gi*4 +: 4] = nib_ff;
        end
    endgenerate

    // named views of the working registers
    wire [3:0] reg_a = rf_flat[3:0];
    wire [3:0] reg_x = rf_flat[7:4];
    wire [3:0] reg_l = rf_flat[11:8];
    wire [3:0] reg_h = rf_flat[15:12];
    wire [3:0] reg_e = rf_flat[19:16];
    wire [3:0] reg_d = rf_flat[23:20];
    wire [3:0] reg_c = rf_flat[27:24];
    wire [3:0] reg_b = rf_flat[31:28];

    assign acc_pair_out = {reg_x, reg_a};
    assign main_pointer_pair_out = {reg_h, reg_l};
    assign second_pair_out = {reg_d, reg_e};
    assign third_pair_out = {reg_b, reg_c};

    // single-nibble pointer address from the selector
    reg [7:0] ptr_addr;
    always @*
    begin
        case (ptr_sel)
            `DTTL_PTR_SECOND: ptr_addr = {reg_d, reg_e}; // RULE_03
            `DTTL_PTR_MIXED: ptr_addr = {reg_d, reg_l}; // RULE_03
            default: ptr_addr = {reg_h, reg_l}; // RULE_03
        endcase
    end

    // pair accesses through the main pointer always land on an even nibble
    wire [7:0] main_even = {reg_h, reg_l[3:1], 1'b0}; // RULE_05
    wire [7:0] base_hi = base_ff + 8'h01;

    // instruction fields
    wire in_reg_op = op_code[`DTTL_OP_CLASS_BIT];
    wire [1:0] in_kind = op_code[`DTTL_OP_KIND_HI:`DTTL_OP_KIND_LO];
    wire in_pair = op_code[`DTTL_OP_PAIR_BIT];
    wire in_direct = op_code[`DTTL_OP_DIRECT_BIT];
    wire [7:0] in_lo_addr = in_direct ? dir_addr
                          : (in_pair ? main_even : ptr_addr); // RULE_07
    wire ff_pair = op_ff[`DTTL_OP_PAIR_BIT];
    wire ff_direct = op_ff[`DTTL_OP_DIRECT_BIT];
    wire ff_swap = (op_ff[`DTTL_OP_KIND_HI:`DTTL_OP_KIND_LO]
                    == `DTTL_KIND_SWAP);

    // page for relative lookups; the page end byte rolls into the next page
    wire last_byte = (pc_in[7:0] == `DTTL_PAGE_LAST);
    wire [3:0] lk_page = last_byte ? (pc_in[11:8] + 4'h1)
                                   : pc_in[11:8]; // RULE_18

    // slot indices for register and pair operands
    wire [3:0] reg_idx = {1'b0, reg_sel};
    wire [3:0] pair_lo = {pair_sel, 1'b0};
    wire [3:0] pair_hi = {pair_sel, 1'b1};
    wire [3:0] sel_reg = rf_flat[{reg_idx, 2'b00} +: 4];
    wire [3:0] sel_lo = rf_flat[{pair_lo, 2'b00} +: 4];
    wire [3:0] sel_hi = rf_flat[{pair_hi, 2'b00} +: 4];

    // next-state logic for the whole datapath
    always @*
    begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_ptr = ptr_ff;
        nxt_base = base_ff;
        nxt_tmp = tmp_ff;
        nxt_rf = rf_flat;
        nxt_dm_addr = dm_addr_ff;
        nxt_dm_wdata = dm_wdata_ff;
        nxt_dm_we = 1'b0;
        nxt_dm_re = 1'b0;
        nxt_pm_addr = pm_addr_ff;
        nxt_pm_re = 1'b0;
        nxt_done = 1'b0;
        nxt_skipped = 1'b0;
        nxt_skip = skip_ff;
        finish = 1'b0;
        fin_ptr = `DTTL_PTR_MAIN;
        new_l = reg_l;
        case (state_ff)
            ST_IDLE:
            begin
                if (op_valid && skip_ff)
                begin
                    // instruction fetched but discarded
                    nxt_skip = 1'b0; // RULE_22
                    nxt_done = 1'b1;
                    nxt_skipped = 1'b1;
                end
                else if (op_valid && !in_reg_op)
                begin
                    nxt_op = op_code;
                    nxt_ptr = ptr_sel;
                    nxt_base = in_lo_addr;
                    nxt_dm_addr = in_lo_addr;
                    if (in_kind == `DTTL_KIND_STORE)
                    begin
                        // low nibble written now, high nibble follows for pair stores only
                        nxt_dm_wdata = reg_a;
                        nxt_dm_we = 1'b1;
                        if (in_pair)
                        begin
                            nxt_tmp = reg_x; // RULE_06
                            nxt_state = ST_WR2;
                        end
                        else
                        begin
                            finish = 1'b1;
                            fin_ptr = in_direct ? `DTTL_PTR_MAIN : ptr_sel;
                        end
                    end
                    else if (in_kind == `DTTL_KIND_LOAD ||
                             in_kind == `DTTL_KIND_SWAP)
                    begin
                        nxt_dm_re = 1'b1;
                        nxt_state = ST_RD1;
                    end
                    else
                        nxt_done = 1'b1; // unused kind: no effect
                end
                else if (op_valid)
                begin
                    nxt_op = op_code;
                    case (op_code[3:0])
                        `DTTL_ROP_A_FROM_REG:
                            nxt_rf[3:0] = sel_reg; // RULE_09
                        `DTTL_ROP_REG_FROM_A:
                            nxt_rf[{reg_idx, 2'b00} +: 4] = reg_a; // RULE_09
                        `DTTL_ROP_SWAP_A_REG:
                        begin
                            nxt_rf[{reg_idx, 2'b00} +: 4] = reg_a; // RULE_14
                            nxt_rf[3:0] = sel_reg; // RULE_14
                        end
                        `DTTL_ROP_ACC_FROM_PAIR:
                            nxt_rf[7:0] = {sel_hi, sel_lo}; // RULE_10
                        `DTTL_ROP_PAIR_FROM_ACC:
                        begin
                            nxt_rf[{pair_lo, 2'b00} +: 4] = reg_a; // RULE_10
                            nxt_rf[{pair_hi, 2'b00} +: 4] = reg_x; // RULE_10
                        end
                        `DTTL_ROP_SWAP_ACC_PAIR:
                        begin
                            nxt_rf[{pair_lo, 2'b00} +: 4] = reg_a; // RULE_14
                            nxt_rf[{pair_hi, 2'b00} +: 4] = reg_x; // RULE_14
                            nxt_rf[7:0] = {sel_hi, sel_lo}; // RULE_14
                        end
                        default:
                            nxt_rf = rf_flat;
                    endcase
                    // lookups fetch a byte; the counter itself is untouched
                    if (op_code[3:0] == `DTTL_ROP_TBL_SECOND)
                    begin
                        nxt_pm_addr = {4'h0, lk_page, reg_d, reg_e}; // RULE_15
                        nxt_pm_re = 1'b1; // RULE_17
                        nxt_state = ST_TBL;
                    end
                    else if (op_code[3:0] == `DTTL_ROP_TBL_ACC)
                    begin
                        nxt_pm_addr = {4'h0, lk_page, reg_x, reg_a}; // RULE_19
                        nxt_pm_re = 1'b1;
                        nxt_state = ST_TBL;
                    end
                    else if (op_code[3:0] == `DTTL_ROP_TBL_ABS)
                    begin
                        // B must already be zero on the small variant
                        nxt_pm_addr = {reg_b, reg_c, reg_d, reg_e}; // RULE_20
                        nxt_pm_re = 1'b1;
                        nxt_state = ST_TBL;
                    end
                    else
                        nxt_done = 1'b1;
                end
            end
            ST_RD1:
            begin
                if (ff_pair)
                begin
                    // low nibble parked until the high one arrives
                    nxt_tmp = dm_rdata;
                    nxt_dm_addr = base_hi;
                    nxt_dm_re = 1'b1;
                    nxt_state = ST_RD2;
                end
                else
                begin
                    nxt_rf[3:0] = dm_rdata;
                    if (ff_swap)
                    begin
                        nxt_dm_wdata = reg_a; // RULE_11
                        nxt_dm_we = 1'b1; // RULE_11
                    end
                    finish = 1'b1;
                    fin_ptr = ff_direct ? `DTTL_PTR_MAIN : ptr_ff; // RULE_12
                    nxt_state = ST_IDLE;
                end
            end
            ST_RD2:
            begin
                nxt_rf[3:0] = tmp_ff; // RULE_04
                nxt_rf[7:4] = dm_rdata; // RULE_04
                if (ff_swap)
                begin
                    // old A goes back now, old X kept for the next cycle
                    nxt_dm_addr = base_ff; // RULE_13
                    nxt_dm_wdata = reg_a; // RULE_13
                    nxt_dm_we = 1'b1;
                    nxt_tmp = reg_x; // RULE_13
                    nxt_state = ST_WR2;
                end
                else
                begin
                    finish = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            ST_WR2:
            begin
                nxt_dm_addr = base_hi; // RULE_06
                nxt_dm_wdata = tmp_ff;
                nxt_dm_we = 1'b1;
                finish = 1'b1;
                nxt_state = ST_IDLE;
            end
            ST_TBL:
            begin
                nxt_rf[3:0] = pm_rdata[3:0]; // RULE_16
                nxt_rf[7:4] = pm_rdata[7:4]; // RULE_16
                nxt_done = 1'b1;
                nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
        // low pointer nibble steps on the edge that completes the instruction, with the last access address already latched
        if (finish)
        begin
            nxt_done = 1'b1;
            if (fin_ptr == `DTTL_PTR_INC)
            begin
                new_l = reg_l + 4'h1; // RULE_01
                nxt_rf[11:8] = new_l;
                nxt_skip = (new_l == `DTTL_INC_WRAP); // RULE_01
            end
            else if (fin_ptr == `DTTL_PTR_DEC)
            begin
                new_l = reg_l - 4'h1; // RULE_02
                nxt_rf[11:8] = new_l;
                nxt_skip = (new_l == `DTTL_DEC_WRAP); // RULE_02
            end
        end
    end

    // sequencing and memory strobes; all outputs leave from flops
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_IDLE;
            op_ff <= 5'h00;
            ptr_ff <= `DTTL_PTR_MAIN;
            base_ff <= `DTTL_RST_ADDR8;
            tmp_ff <= `DTTL_RST_NIB;
            dm_addr_ff <= `DTTL_RST_ADDR8;
            dm_wdata_ff <= `DTTL_RST_NIB;
            dm_we_ff <= 1'b0;
            dm_re_ff <= 1'b0;
            pm_addr_ff <= `DTTL_RST_ADDR16;
            pm_re_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            skipped_ff <= 1'b0;
            skip_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            ptr_ff <= nxt_ptr;
            base_ff <= nxt_base;
            tmp_ff <= nxt_tmp;
            dm_addr_ff <= nxt_dm_addr;
            dm_wdata_ff <= nxt_dm_wdata;
            dm_we_ff <= nxt_dm_we;
            dm_re_ff <= nxt_dm_re;
            pm_addr_ff <= nxt_pm_addr;
            pm_re_ff <= nxt_pm_re;
            busy_ff <= (nxt_state != ST_IDLE);
            done_ff <= nxt_done;
            skipped_ff <= nxt_skipped;
            skip_ff <= nxt_skip; // RULE_22
        end
    end

endmodule // dttl_core

// ==== dttl_defines.vh ====
// constants shared by the transfer and table lookup datapath
// assumes a single 20 MHz core clock and memories on that same clock
`ifndef DTTL_DEFINES_VH
`define DTTL_DEFINES_VH

// clock period in ns, kept for reference by timing figures
`define DTTL_CLK_PERIOD_NS 50

// memory operation fields: op[4]=0, op[3:2]=kind, op[1]=pair, op[0]=direct
`define DTTL_OP_CLASS_BIT 4
`define DTTL_OP_KIND_HI 3
`define DTTL_OP_KIND_LO 2
`define DTTL_OP_PAIR_BIT 1
`define DTTL_OP_DIRECT_BIT 0
`define DTTL_KIND_LOAD 2'h0
`define DTTL_KIND_STORE 2'h1
`define DTTL_KIND_SWAP 2'h2

// register operation codes, op[4]=1
`define DTTL_ROP_A_FROM_REG 4'h0
`define DTTL_ROP_REG_FROM_A 4'h1
`define DTTL_ROP_SWAP_A_REG 4'h2
`define DTTL_ROP_ACC_FROM_PAIR 4'h3
`define DTTL_ROP_PAIR_FROM_ACC 4'h4
`define DTTL_ROP_SWAP_ACC_PAIR 4'h5
`define DTTL_ROP_TBL_SECOND 4'h6
`define DTTL_ROP_TBL_ACC 4'h7
`define DTTL_ROP_TBL_ABS 4'h8

// data memory pointer selector
`define DTTL_PTR_MAIN 3'h0
`define DTTL_PTR_INC 3'h1
`define DTTL_PTR_DEC 3'h2
`define DTTL_PTR_SECOND 3'h3
`define DTTL_PTR_MIXED 3'h4

// nibble slots of the working register file (pair*2 + high)
`define DTTL_NIB_A 4'h0
`define DTTL_NIB_X 4'h1
`define DTTL_NIB_L 4'h2
`define DTTL_NIB_H 4'h3
`define DTTL_NIB_E 4'h4
`define DTTL_NIB_D 4'h5
`define DTTL_NIB_C 4'h6
`define DTTL_NIB_B 4'h7

// pointer wrap values that request a skip, and the page end byte
`define DTTL_INC_WRAP 4'h0
`define DTTL_DEC_WRAP 4'hF
`define DTTL_PAGE_LAST 8'hFF

// reset values
`define DTTL_RST_NIB 4'h0
`define DTTL_RST_ADDR8 8'h00
`define DTTL_RST_ADDR16 16'h0000

`endif

// ==== dttl_mem_model.sv ====
// data and program memory partner for the transfer datapath
// assumes reads answer while the strobe stands, same clock as core
module dttl_mem_model (
    input logic clock,
    input logic [7:0] dm_addr_ff,
    input logic [3:0] dm_wdata_ff,
    input logic dm_we_ff,
    input logic dm_re_ff,
    input logic [15:0] pm_addr_ff,
    input logic pm_re_ff,
    output logic [3:0] dm_rdata,
    output logic [7:0] pm_rdata
);
timeunit 1ns;
timeprecision 1ns;
logic [3:0] dm [0:255];
logic [7:0] pm_byte;

// table contents are a fixed mix of the address bits
assign pm_byte = pm_addr_ff[7:0] ^ {pm_addr_ff[11:8], pm_addr_ff[15:12]};

// core samples read data in the strobe cycle itself; outside it the
// inverse shows, so a read taken a cycle off goes visibly wrong
assign dm_rdata = dm_re_ff ? dm[dm_addr_ff] : ~dm[dm_addr_ff];
assign pm_rdata = pm_re_ff ? pm_byte : ~pm_byte;

// writes land on the edge that samples the write strobe
always @(posedge clock)
begin
    if (dm_we_ff)
        dm[dm_addr_ff] <= dm_wdata_ff;
end
endmodule // dttl_mem_model

// ==== dttl_core_checker.sv ====
// timing checks on the ports of dttl_core
// assumes the single core clock and the async active-low reset
module dttl_core_checker (
    input wire clock,
    input wire rst_b,
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [2:0] ptr_sel,
    input wire [11:0] pc_in,
    input wire [7:0] dm_addr_ff,
    input wire [3:0] dm_wdata_ff,
    input wire dm_we_ff,
    input wire dm_re_ff,
    input wire [15:0] pm_addr_ff,
    input wire pm_re_ff,
    input wire busy_ff,
    input wire done_ff,
    input wire skip_ff,
    input wire [7:0] acc_pair_out,
    input wire [7:0] main_pointer_pair_out,
    input wire [7:0] second_pair_out,
    input wire [7:0] third_pair_out
);
wire tk;
wire [15:0] pg_exp;
wire [15:0] abs_exp;
wire [7:0] ptr_pair;

// an op taken normally; page carry when sitting on the last byte
assign tk = op_valid & ~busy_ff & ~skip_ff;
assign ptr_pair = main_pointer_pair_out;
assign pg_exp = {4'h0, pc_in[11:8] + {3'h0, &pc_in[7:0]}, second_pair_out};
assign abs_exp = {third_pair_out, second_pair_out};

default clocking cb @(posedge clock);
endclocking
default disable iff (!rst_b);

a_done_idle:
assert property (done_ff |-> !busy_ff)
    else $error("busy while done");
a_skip_take:
assert property (op_valid && !busy_ff && skip_ff |=>
    done_ff && dm_we_ff == 1'b0 && !skip_ff)
    else $error("skipped op not consumed");
a_skip_rise:
assert property ($rose(skip_ff) |-> done_ff)
    else $error("skip set outside completion");
a_reg_lat:
assert property (tk && op_code[4] && op_code[3:0] < 4'h6 |=> done_ff)
    else $error("register op latency");
a_busy_bound:
assert property (busy_ff |-> ##[1:4] done_ff)
    else $error("op never completes");
a_tbl_page:
assert property (tk && op_code == 5'h16 |=>
    pm_re_ff && pm_addr_ff == $past(pg_exp))
    else $error("page lookup address wrong");
a_tbl_abs:
assert property (tk && op_code == 5'h18 |=>
    pm_re_ff && pm_addr_ff == $past(abs_exp))
    else $error("absolute lookup address wrong");
a_pair_align:
assert property (tk && (op_code == 5'h02 || op_code == 5'h0A) |=>
    dm_re_ff && dm_addr_ff == {ptr_pair[7:1], 1'b0} ##1
    dm_re_ff && dm_addr_ff == {ptr_pair[7:1], 1'b1})
    else $error("pair address not aligned");
a_store_one:
assert property (tk && op_code == 5'h04 && ptr_sel == 3'h0 |=>
    dm_we_ff && done_ff && dm_addr_ff == ptr_pair &&
    dm_wdata_ff == acc_pair_out[3:0])
    else $error("single store wrong");
endmodule // dttl_core_checker

bind dttl_core dttl_core_checker u_chk (
    .clock, .rst_b, .op_valid, .op_code, .ptr_sel, .pc_in, .dm_addr_ff,
    .dm_wdata_ff, .dm_we_ff, .dm_re_ff, .pm_addr_ff, .pm_re_ff, .busy_ff,
    .done_ff, .skip_ff, .acc_pair_out, .main_pointer_pair_out,
    .second_pair_out, .third_pair_out
);

// ==== dttl_core_tb.sv ====
// self-checking bench for dttl_core with a memory partner model
// assumes memories answer in the cycle in which a strobe stands
module dttl_core_tb;
timeunit 1ns;
timeprecision 1ns;
logic clock = 1'b0;
logic rst_b = 1'b0;
logic op_valid = 1'b0;
logic [4:0] op_code = 5'h00;
logic [2:0] ptr_sel = 3'h0;
logic [2:0] reg_sel = 3'h0;
logic [2:0] pair_sel = 3'h0;
logic [7:0] dir_addr = 8'h00;
logic [11:0] pc_in = 12'h000;
logic sk;
int n_fail = 0;
int comparisons = 0;
int cyc = 0;
wire [3:0] dm_rdata, dm_wdata_ff;
wire [7:0] pm_rdata, dm_addr_ff, accp, ptrp, secp, thrp;
wire [15:0] pm_addr_ff;
wire dm_we_ff, dm_re_ff, pm_re_ff, busy_ff, done_ff, skipped_ff, skip_ff;

dttl_core u_dut (
    .clock, .rst_b, .op_valid, .op_code, .ptr_sel, .reg_sel, .pair_sel,
    .dir_addr, .pc_in, .dm_rdata, .pm_rdata, .dm_addr_ff, .dm_wdata_ff,
    .dm_we_ff, .dm_re_ff, .pm_addr_ff, .pm_re_ff, .busy_ff, .done_ff,
    .skipped_ff, .skip_ff, .acc_pair_out(accp),
    .main_pointer_pair_out(ptrp), .second_pair_out(secp),
    .third_pair_out(thrp)
);

dttl_mem_model u_mem (
    .clock, .dm_addr_ff, .dm_wdata_ff, .dm_we_ff, .dm_re_ff,
    .pm_addr_ff, .pm_re_ff, .dm_rdata, .pm_rdata
);

// 20 MHz core clock
always #25 clock = ~clock;

// hang guard, far above the roughly 200 cycles needed
always @(posedge clock)
begin
    cyc++;
    if (cyc == 3000)
    begin
        n_fail++;
        end_of_test;
    end
end

task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
        n_fail++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
endtask

// one selector value feeds all three selects; unused ones are ignored
task op(input logic [4:0] c, input logic [2:0] s, input logic [7:0] d);
    int n;
    n = 0;
    op_code = c;
    ptr_sel = s;
    reg_sel = s;
    pair_sel = s;
    dir_addr = d;
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
    while (done_ff !== 1'b1 && n < 9)
    begin
        @(negedge clock);
        n++;
    end
    chk(done_ff, 1'b1);
    sk = skipped_ff;
    // let the last memory write land before anyone looks
    @(negedge clock);
endtask

// no immediate loads here, so registers are filled through memory
task ld(input logic [2:0] r, input logic [3:0] v);
    u_mem.dm[8'hF0] = v;
    op(5'h01, 3'h0, 8'hF0);
    if (r != 3'h0)
        op(5'h11, r, 8'h00);
endtask

task t_inc;
    ld(3'h3, 4'h2);
    ld(3'h2, 4'hF);
    u_mem.dm[8'h2F] = 4'h9;
    op(5'h00, 3'h1, 8'h00);
    chk({accp[3:0], ptrp, skip_ff}, {12'h920, 1'b1});
    op(5'h11, 3'h1, 8'h00);
    chk({sk, skip_ff, accp}, {2'b10, 8'h09});
endtask

task t_dec;
    ld(3'h2, 4'h1);
    ld(3'h0, 4'h6);
    u_mem.dm[8'h21] = 4'hC;
    u_mem.dm[8'h20] = 4'h3;
    op(5'h08, 3'h2, 8'h00);
    chk({accp[3:0], u_mem.dm[8'h21], ptrp, skip_ff}, 17'h18C40);
    op(5'h08, 3'h2, 8'h00);
    chk({accp[3:0], u_mem.dm[8'h20], ptrp, skip_ff}, 17'h0785F);
    op(5'h04, 3'h0, 8'h00);
    chk({sk, skip_ff, u_mem.dm[8'h2F]}, 6'h29);
endtask

task t_pair;
    ld(3'h3, 4'h3);
    ld(3'h2, 4'hF);
    u_mem.dm[8'h3E] = 4'h1;
    u_mem.dm[8'h3F] = 4'h8;
    op(5'h02, 3'h0, 8'h00);
    chk(accp, 8'h81);
    ld(3'h0, 4'h7);
    op(5'h06, 3'h0, 8'h00);
    chk({u_mem.dm[8'h3F], u_mem.dm[8'h3E]}, 8'h87);
    u_mem.dm[8'h3E] = 4'h2;
    u_mem.dm[8'h3F] = 4'h5;
    op(5'h0A, 3'h0, 8'h00);
    chk({accp, u_mem.dm[8'h3F], u_mem.dm[8'h3E]}, 16'h5287);
endtask

task t_mix;
    ld(3'h5, 4'h2);
    ld(3'h4, 4'h7);
    u_mem.dm[8'h27] = 4'hE;
    u_mem.dm[8'h2F] = 4'h6;
    op(5'h00, 3'h3, 8'h00);
    chk(accp[3:0], 4'hE);
    op(5'h04, 3'h0, 8'h00);
    op(5'h00, 3'h0, 8'h00);
    chk({accp[3:0], ptrp}, 12'hE3F);
    op(5'h00, 3'h4, 8'h00);
    chk(accp[3:0], 4'h6);
endtask

task t_dir;
    u_mem.dm[8'hFF] = 4'hD;
    u_mem.dm[8'h40] = 4'h4;
    u_mem.dm[8'h41] = 4'hB;
    op(5'h01, 3'h0, 8'hFF);
    chk(accp[3:0], 4'hD);
    op(5'h03, 3'h0, 8'h40);
    chk(accp, 8'hB4);
    op(5'h07, 3'h0, 8'hFE);
    chk({u_mem.dm[8'hFF], u_mem.dm[8'hFE]}, 8'hB4);
    u_mem.dm[8'h40] = 4'h1;
    u_mem.dm[8'h41] = 4'h2;
    op(5'h0B, 3'h0, 8'h40);
    chk({accp, u_mem.dm[8'h41], u_mem.dm[8'h40]}, 16'h21B4);
    op(5'h09, 3'h0, 8'hFF);
    chk({accp[3:0], u_mem.dm[8'hFF]}, 8'hB1);
    op(5'h05, 3'h0, 8'hFF);
    chk(u_mem.dm[8'hFF], 4'hB);
endtask

task t_reg;
    for (int k = 1; k < 8; k++)
        ld(k[2:0], 4'h8 + k[3:0]);
    chk({accp, ptrp, secp, thrp}, 32'h9FBADCFE);
    for (int k = 1; k < 8; k++)
    begin
        op(5'h10, k[2:0], 8'h00);
        chk(accp[3:0], 8 + k);
    end
    op(5'h12, 3'h2, 8'h00);
    chk({accp, ptrp}, 16'h9ABF);
    op(5'h13, 3'h2, 8'h00);
    chk(accp, 8'hDC);
    op(5'h14, 3'h4, 8'h00);
    op(5'h13, 3'h3, 8'h00);
    op(5'h15, 3'h4, 8'h00);
    chk(accp, 8'hDC);
    op(5'h13, 3'h4, 8'h00);
    chk(accp, 8'hFE);
    op(5'h15, 3'h1, 8'h00);
    op(5'h14, 3'h2, 8'h00);
    chk({accp, ptrp, secp}, 24'hBFFEBF);
endtask

task t_tbl;
    pc_in = 12'h2FE;
    op(5'h16, 3'h0, 8'h00);
    chk(accp, 8'h9F);
    pc_in = 12'h2FF;
    op(5'h16, 3'h0, 8'h00);
    chk(accp, 8'h8F);
    pc_in = 12'h512;
    op(5'h17, 3'h0, 8'h00);
    chk(accp, 8'hDF);
    op(5'h18, 3'h0, 8'h00);
    chk(accp, 8'h50);
    ld(3'h7, 4'h0);
    op(5'h18, 3'h0, 8'h00);
    chk({accp, thrp}, 16'h5F0E);
endtask

task end_of_test;
    if (n_fail == 0 && comparisons > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
endtask

// reset for four cycles, then every scenario in turn
initial
begin
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    t_inc;
    t_dec;
    t_pair;
    t_mix;
    t_dir;
    t_reg;
    t_tbl;
    end_of_test;
end
endmodule // dttl_core_tb
